/* File: power_mode_pkg.sv */
package power_mode_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_REQ_ADDR = 8'h00;
    localparam logic [7:0] MODE_STAT_ADDR = 8'h04;
    localparam logic [7:0] ACT_TMPL_ADDR = 8'h08;
    localparam logic [7:0] ALT_TMPL_ADDR = 8'h0C;
    localparam logic [7:0] WAKE_EN_ADDR = 8'h10;
    localparam logic [7:0] REG_CTRL_ADDR = 8'h14;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h18;
    localparam logic [7:0] IRQ_EN_ADDR = 8'h1C;
    localparam logic [7:0] IRQ_CLR_ADDR = 8'h20;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int SUBSYS_W = 8;
    localparam int CPU_BIT = 0;
    localparam logic [7:0] ACT_TMPL_RST = 8'hFF;
    localparam logic [7:0] ALT_TMPL_RST = 8'hFE;
    localparam logic [5:0] WAKE_EN_RST = 6'h3F;
    // Regulator control: bit0 digital, bit1 analog, bit2 crystal high power
    localparam logic [2:0] REG_CTRL_RST = 3'h3;
    localparam int WAKE_W = 6;
    // Wake source bit positions
    localparam int WK_COMP = 0;
    localparam int WK_PIN = 1;
    localparam int WK_I2C = 2;
    localparam int WK_RTC = 3;
    localparam int WK_TIMEWHEEL = 4;
    localparam int WK_BROWNOUT = 5;
    // Interrupt status bits
    localparam int IRQ_W = 3;
    localparam int IRQ_SECOND = 0;
    localparam int IRQ_WAKE = 1;
    localparam int IRQ_BADREQ = 2;

    // ------------------------------------------------------------
    // Mode codes
    // ------------------------------------------------------------
    localparam logic [1:0] CODE_ACTIVE = 2'h0;
    localparam logic [1:0] CODE_ALT = 2'h1;
    localparam logic [1:0] CODE_SLEEP = 2'h2;
    localparam logic [1:0] CODE_HIBERNATE = 2'h3;

    typedef enum logic [4:0] {
        ST_ACTIVE = 5'h01,
        ST_ALT = 5'h02,
        ST_SLEEP = 5'h04,
        ST_HIBERNATE = 5'h08,
        ST_RESUME = 5'h10
    } mode_type;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20000000;
    localparam int RESUME_NS = 15000;
    localparam int RESUME_CYC = (RESUME_NS * (CLK_HZ / 1000000)) / 1000;
    localparam logic [9:0] RESUME_CYC_V = 10'(RESUME_CYC);
    localparam logic [3:0] BUZZ_PERIOD = 4'hF;
    localparam logic [14:0] XTAL_PER_SEC = 15'h7FFF;

endpackage : power_mode_pkg

/* File: power_mode_controller.sv */
`timescale 1ns/1ps
`default_nettype none

module power_mode_controller (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instrDone,
    input wire logic anyIrq,
    input wire logic [5:0] wakeSrc,
    input wire logic xtalTick,
    output logic [7:0] subsysClkEn,
    output logic mainClkEn,
    output logic slowClkEn,
    output logic digRegEn,
    output logic anaRegEn,
    output logic hibRegEn,
    output logic xtalHighPower,
    output logic irq
);

    // ------------------------------------------------------------
    // Input synchronisers for pin-side events
    // ------------------------------------------------------------
    logic [5:0] wakeMeta_q, wakeSync_q;
    logic tickMeta_q, tickSync_q, tickPrev_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wakeMeta_q <= 6'h00;
            wakeSync_q <= 6'h00;
            tickMeta_q <= 1'b0;
            tickSync_q <= 1'b0;
            tickPrev_q <= 1'b0;
        end else begin
            wakeMeta_q <= wakeSrc;
            wakeSync_q <= wakeMeta_q;
            tickMeta_q <= xtalTick;
            tickSync_q <= tickMeta_q;
            tickPrev_q <= tickSync_q;
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    power_mode_pkg::mode_type mode_q, mode_d;
    logic [1:0] pendCode_q, pendCode_d;
    logic pend_q, pend_d;
    logic [9:0] resumeCnt_q, resumeCnt_d;
    logic [3:0] buzzCnt_q, buzzCnt_d;
    logic [14:0] secCnt_q, secCnt_d;
    logic [7:0] actTmpl_q, actTmpl_d, altTmpl_q, altTmpl_d;
    logic [5:0] wakeEn_q, wakeEn_d;
    logic [2:0] regCtrl_q, regCtrl_d;
    logic [2:0] irqStat_q, irqStat_d, irqEn_q, irqEn_d;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d;
    logic [7:0] subsysClkEn_d;
    logic mainClkEn_d, slowClkEn_d, digRegEn_d, anaRegEn_d, hibRegEn_d, irq_d;

    logic wrAcc, wrDone, rdAcc, sleepWake, hibWake, actWake, secEvt, badReq, wakeEvt;

    always_comb begin
        wrAcc = psel && penable && pwrite && !pready;
        // Writes land on the completing edge, where the master sees pready high
        wrDone = psel && penable && pwrite && pready;
        rdAcc = psel && penable && !pwrite && !pready;
        sleepWake = |(wakeSync_q & wakeEn_q);
        hibWake = wakeSync_q[power_mode_pkg::WK_PIN];
        actWake = anyIrq;
        secEvt = tickSync_q && !tickPrev_q;

        // Register writes
        actTmpl_d = actTmpl_q;
        altTmpl_d = altTmpl_q;
        wakeEn_d = wakeEn_q;
        regCtrl_d = regCtrl_q;
        irqEn_d = irqEn_q;
        pendCode_d = pendCode_q;
        pend_d = pend_q;
        badReq = 1'b0;
        if (wrDone) begin
            unique case (paddr)
                power_mode_pkg::MODE_REQ_ADDR: begin
                    pendCode_d = pwdata[1:0];
                    pend_d = 1'b1;
                end
                power_mode_pkg::ACT_TMPL_ADDR: actTmpl_d = pwdata[7:0];
                power_mode_pkg::ALT_TMPL_ADDR: altTmpl_d = pwdata[7:0];
                power_mode_pkg::WAKE_EN_ADDR: wakeEn_d = pwdata[5:0];
                power_mode_pkg::REG_CTRL_ADDR: regCtrl_d = pwdata[2:0];
                power_mode_pkg::IRQ_EN_ADDR: irqEn_d = pwdata[2:0];
                default: ;
            endcase
        end

        // Mode sequencing
        mode_d = mode_q;
        resumeCnt_d = resumeCnt_q;
        wakeEvt = 1'b0;
        unique case (mode_q)
            power_mode_pkg::ST_ACTIVE, power_mode_pkg::ST_ALT: begin
                if (mode_q == power_mode_pkg::ST_ALT && actWake) begin
                    mode_d = power_mode_pkg::ST_ACTIVE;
                    wakeEvt = 1'b1;
                end else if (pend_q && instrDone) begin
                    pend_d = 1'b0;
                    unique case (pendCode_q)
                        power_mode_pkg::CODE_ACTIVE: mode_d = power_mode_pkg::ST_ACTIVE;
                        power_mode_pkg::CODE_ALT: mode_d = power_mode_pkg::ST_ALT;
                        power_mode_pkg::CODE_SLEEP: begin
                            if (mode_q == power_mode_pkg::ST_ACTIVE) begin
                                mode_d = power_mode_pkg::ST_SLEEP;
                            end else begin
                                badReq = 1'b1;
                            end
                        end
                        power_mode_pkg::CODE_HIBERNATE: begin
                            if (mode_q == power_mode_pkg::ST_ACTIVE) begin
                                mode_d = power_mode_pkg::ST_HIBERNATE;
                            end else begin
                                badReq = 1'b1;
                            end
                        end
                    endcase
                end
            end
            power_mode_pkg::ST_SLEEP: begin
                if (sleepWake) begin
                    mode_d = power_mode_pkg::ST_RESUME;
                    resumeCnt_d = power_mode_pkg::RESUME_CYC_V;
                end
            end
            power_mode_pkg::ST_HIBERNATE: begin
                if (hibWake) begin
                    mode_d = power_mode_pkg::ST_RESUME;
                    resumeCnt_d = power_mode_pkg::RESUME_CYC_V;
                end
            end
            power_mode_pkg::ST_RESUME: begin
                if (resumeCnt_q <= 10'h001) begin
                    mode_d = power_mode_pkg::ST_ACTIVE;
                    wakeEvt = 1'b1;
                end else begin
                    resumeCnt_d = resumeCnt_q - 10'h001;
                end
            end
            default: mode_d = power_mode_pkg::ST_ACTIVE;
        endcase

        // The processor comes back on any wakeup, whatever its template bit says
        if (wakeEvt) begin
            actTmpl_d[power_mode_pkg::CPU_BIT] = 1'b1;
        end

        // Requests arriving outside active modes are dropped
        if (mode_q != power_mode_pkg::ST_ACTIVE && mode_q != power_mode_pkg::ST_ALT) begin
            pend_d = 1'b0;
        end

        // Regulator buzz timer runs only while asleep
        buzzCnt_d = (mode_q == power_mode_pkg::ST_SLEEP) ? buzzCnt_q + 4'h1 : 4'h0;

        // One-second tick from the crystal count
        secCnt_d = secCnt_q;
        if (secEvt) begin
            secCnt_d = (secCnt_q == power_mode_pkg::XTAL_PER_SEC) ? 15'h0000 : secCnt_q + 15'h0001;
        end

        // Sticky status: set wins over clear
        irqStat_d = irqStat_q;
        if (wrDone && paddr == power_mode_pkg::IRQ_CLR_ADDR) begin
            irqStat_d = irqStat_q & ~pwdata[2:0];
        end
        if (secEvt && secCnt_q == power_mode_pkg::XTAL_PER_SEC) begin
            irqStat_d[power_mode_pkg::IRQ_SECOND] = 1'b1;
        end
        if (wakeEvt) begin
            irqStat_d[power_mode_pkg::IRQ_WAKE] = 1'b1;
        end
        if (badReq) begin
            irqStat_d[power_mode_pkg::IRQ_BADREQ] = 1'b1;
        end

        // APB answer: one wait state
        pready_d = psel && penable && !pready;
        pslverr_d = 1'b0;
        prdata_d = 32'h0000_0000;
        if (rdAcc) begin
            unique case (paddr)
                power_mode_pkg::MODE_REQ_ADDR: prdata_d = {29'h0, pend_q, pendCode_q};
                power_mode_pkg::MODE_STAT_ADDR: prdata_d = {27'h0, mode_q};
                power_mode_pkg::ACT_TMPL_ADDR: prdata_d = {24'h0, actTmpl_q};
                power_mode_pkg::ALT_TMPL_ADDR: prdata_d = {24'h0, altTmpl_q};
                power_mode_pkg::WAKE_EN_ADDR: prdata_d = {26'h0, wakeEn_q};
                power_mode_pkg::REG_CTRL_ADDR: prdata_d = {29'h0, regCtrl_q};
                power_mode_pkg::IRQ_STAT_ADDR: prdata_d = {29'h0, irqStat_q};
                power_mode_pkg::IRQ_EN_ADDR: prdata_d = {29'h0, irqEn_q};
                power_mode_pkg::IRQ_CLR_ADDR: prdata_d = 32'h0000_0000;
                default: pslverr_d = 1'b1;
            endcase
        end else if (wrAcc) begin
            pslverr_d = !(paddr inside {power_mode_pkg::MODE_REQ_ADDR, power_mode_pkg::ACT_TMPL_ADDR,
                power_mode_pkg::ALT_TMPL_ADDR, power_mode_pkg::WAKE_EN_ADDR,
                power_mode_pkg::REG_CTRL_ADDR, power_mode_pkg::IRQ_EN_ADDR,
                power_mode_pkg::IRQ_CLR_ADDR});
        end

        // Power outputs per mode
        subsysClkEn_d = 8'h00;
        mainClkEn_d = 1'b0;
        slowClkEn_d = 1'b1;
        digRegEn_d = 1'b0;
        anaRegEn_d = 1'b0;
        hibRegEn_d = 1'b1;
        unique case (mode_d)
            power_mode_pkg::ST_ACTIVE: begin
                subsysClkEn_d = actTmpl_d;
                mainClkEn_d = 1'b1;
                digRegEn_d = regCtrl_d[0];
                anaRegEn_d = regCtrl_d[1];
            end
            power_mode_pkg::ST_ALT: begin
                subsysClkEn_d = altTmpl_d;
                mainClkEn_d = 1'b1;
                digRegEn_d = regCtrl_d[0];
                anaRegEn_d = regCtrl_d[1];
            end
            power_mode_pkg::ST_SLEEP: begin
                // Template ignored; regulators pulse once per buzz period
                digRegEn_d = regCtrl_d[0] && (buzzCnt_d == 4'h0);
                anaRegEn_d = regCtrl_d[1] && (buzzCnt_d == 4'h0);
            end
            power_mode_pkg::ST_HIBERNATE: begin
                slowClkEn_d = 1'b0;
            end
            power_mode_pkg::ST_RESUME: begin
                // Regulators settle before clocks return
                digRegEn_d = regCtrl_d[0];
                anaRegEn_d = regCtrl_d[1];
            end
            default: ;
        endcase
        irq_d = |(irqStat_d & irqEn_d);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= power_mode_pkg::ST_ACTIVE;
            pendCode_q <= power_mode_pkg::CODE_ACTIVE;
            pend_q <= 1'b0;
            resumeCnt_q <= 10'h000;
            buzzCnt_q <= 4'h0;
            secCnt_q <= 15'h0000;
            actTmpl_q <= power_mode_pkg::ACT_TMPL_RST;
            altTmpl_q <= power_mode_pkg::ALT_TMPL_RST;
            wakeEn_q <= power_mode_pkg::WAKE_EN_RST;
            regCtrl_q <= power_mode_pkg::REG_CTRL_RST;
            irqStat_q <= 3'h0;
            irqEn_q <= 3'h0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            subsysClkEn <= power_mode_pkg::ACT_TMPL_RST;
            mainClkEn <= 1'b1;
            slowClkEn <= 1'b1;
            digRegEn <= 1'b1;
            anaRegEn <= 1'b1;
            hibRegEn <= 1'b1;
            xtalHighPower <= 1'b0;
            irq <= 1'b0;
        end else begin
            mode_q <= mode_d;
            pendCode_q <= pendCode_d;
            pend_q <= pend_d;
            resumeCnt_q <= resumeCnt_d;
            buzzCnt_q <= buzzCnt_d;
            secCnt_q <= secCnt_d;
            actTmpl_q <= actTmpl_d;
            altTmpl_q <= altTmpl_d;
            wakeEn_q <= wakeEn_d;
            regCtrl_q <= regCtrl_d;
            irqStat_q <= irqStat_d;
            irqEn_q <= irqEn_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
            subsysClkEn <= subsysClkEn_d;
            mainClkEn <= mainClkEn_d;
            slowClkEn <= slowClkEn_d;
            digRegEn <= digRegEn_d;
            anaRegEn <= anaRegEn_d;
            hibRegEn <= hibRegEn_d;
            xtalHighPower <= regCtrl_d[2];
            irq <= irq_d;
        end
    end

endmodule : power_mode_controller

`default_nettype wire

/* File: power_mode_controller_sva.sv */
`timescale 1ns/1ps
`default_nettype none

module power_mode_controller_sva (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic instrDone,
    input wire logic [7:0] subsysClkEn,
    input wire logic mainClkEn,
    input wire logic slowClkEn,
    input wire logic digRegEn,
    input wire logic anaRegEn,
    input wire logic hibRegEn
);
    // ------------------------------------------------------------
    // Resume length counter
    // ------------------------------------------------------------
    // Counts cycles with clocks off and both regulators up; a buzz pulse is one cycle only
    logic [9:0] resumeCnt_q;
    logic [9:0] resumeCnt_d;

    always_comb begin
        resumeCnt_d = 10'h000;
        if (!mainClkEn && digRegEn && anaRegEn) begin
            resumeCnt_d = resumeCnt_q + 10'h001;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            resumeCnt_q <= 10'h000;
        end else begin
            resumeCnt_q <= resumeCnt_d;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("access phase not answered after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    err_qual_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    gate_sub_a: assert property (!mainClkEn |-> subsysClkEn == 8'h00)
        else $error("subsystem clock running with main clock off");
    hib_clk_a: assert property (!slowClkEn |-> !mainClkEn)
        else $error("main clock on while slow clock stopped");
    hib_reg_a: assert property (!slowClkEn && !digRegEn |-> !anaRegEn && hibRegEn)
        else $error("wrong regulator set in hibernate");
    entry_instr_a: assert property ($fell(mainClkEn) |-> $past(instrDone))
        else $error("mode entry without completed instruction");
    wake_cpu_a: assert property ($rose(mainClkEn) |-> subsysClkEn[power_mode_pkg::CPU_BIT])
        else $error("processor clock off after wakeup");
    resume_len_a: assert property (resumeCnt_q <= 10'h12D)
        else $error("resume longer than allowed");

endmodule : power_mode_controller_sva

bind power_mode_controller power_mode_controller_sva i_sva (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .instrDone(instrDone),
    .subsysClkEn(subsysClkEn), .mainClkEn(mainClkEn), .slowClkEn(slowClkEn),
    .digRegEn(digRegEn), .anaRegEn(anaRegEn), .hibRegEn(hibRegEn)
);

`default_nettype wire

/* File: power_mode_controller_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module power_mode_controller_tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic instrDone = 1'b0;
    logic anyIrq = 1'b0;
    logic [5:0] wakeSrc = 6'h00;
    logic xtalTick = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, mainClkEn, slowClkEn, digRegEn, anaRegEn, hibRegEn, xtalHighPower, irq;
    logic [7:0] subsysClkEn;
    logic [31:0] rd;
    logic err;
    int nErrors = 0;
    int checksDone = 0;
    int n;
    logic [7:0] addrs [8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
    logic [31:0] rsts [8] = '{32'h01, 32'hFF, 32'hFE, 32'h3F, 32'h03, 32'h00, 32'h00, 32'h00};

    power_mode_controller i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instrDone(instrDone), .anyIrq(anyIrq), .wakeSrc(wakeSrc), .xtalTick(xtalTick),
        .subsysClkEn(subsysClkEn), .mainClkEn(mainClkEn), .slowClkEn(slowClkEn),
        .digRegEn(digRegEn), .anaRegEn(anaRegEn), .hibRegEn(hibRegEn),
        .xtalHighPower(xtalHighPower), .irq(irq)
    );

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic step(input int c);
        repeat (c) @(posedge clk_sys);
    endtask : step

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nErrors++;
            $display("ERROR at %0t: seen %08h expected %08h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) chk(32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdChk

    // Mode is applied only at an edge where the instruction has completed
    task automatic pulse();
        step(2);
        instrDone <= 1'b1;
        step(1);
        instrDone <= 1'b0;
        step(3);
    endtask : pulse

    // Bounded wait for the main clock to return; n holds the cycles taken
    task automatic waitWake();
        n = 0;
        while (mainClkEn !== 1'b1 && n < 400) begin
            step(1);
            n++;
        end
    endtask : waitWake

    task automatic printVerdict();
        $display("errors %0d checks %0d", nErrors, checksDone);
        if (nErrors == 0 && checksDone > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : printVerdict

    initial begin
        repeat (90000) @(posedge clk_sys);
        nErrors++;
        printVerdict();
    end

    initial begin
        step(4);
        chk(32'({subsysClkEn, mainClkEn, slowClkEn, digRegEn, anaRegEn, hibRegEn,
            xtalHighPower, irq}), 32'h7FFC);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rdChk(addrs[i], rsts[i]);
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
        wr(8'h40, 32'h5);
        chk(32'(err), 32'h1);
        wr(power_mode_pkg::ACT_TMPL_ADDR, 32'h5A);
        step(3);
        chk(32'(subsysClkEn), 32'h5A);
        // Processor bit off in both templates, so only a wakeup can bring it back
        wr(power_mode_pkg::ACT_TMPL_ADDR, 32'hFE);
        wr(power_mode_pkg::ALT_TMPL_ADDR, 32'hA4);
        // Alternate mode: request waits for instruction completion
        wr(power_mode_pkg::MODE_REQ_ADDR, 32'h1);
        step(4);
        rdChk(power_mode_pkg::MODE_STAT_ADDR, 32'h01);
        pulse();
        rdChk(power_mode_pkg::MODE_STAT_ADDR, 32'h02);
        chk(32'(subsysClkEn), 32'hA4);
        for (int c = 2; c < 4; c++) begin
            wr(power_mode_pkg::MODE_REQ_ADDR, 32'(c));
            pulse();
            rdChk(power_mode_pkg::MODE_STAT_ADDR, 32'h02);
        end
        rdChk(power_mode_pkg::IRQ_STAT_ADDR, 32'h4);
        anyIrq <= 1'b1;
        step(5);
        anyIrq <= 1'b0;
        rdChk(power_mode_pkg::MODE_STAT_ADDR, 32'h01);
        chk(32'(subsysClkEn[power_mode_pkg::CPU_BIT]), 32'h1);
        rdChk(power_mode_pkg::ACT_TMPL_ADDR, 32'hFF);
        rdChk(power_mode_pkg::IRQ_STAT_ADDR, 32'h6);
        chk(32'(irq), 32'h0);
        wr(power_mode_pkg::IRQ_EN_ADDR, 32'h2);
        step(3);
        chk(32'(irq), 32'h1);
        wr(power_mode_pkg::IRQ_CLR_ADDR, 32'h7);
        step(3);
        chk(32'(irq), 32'h0);
        // Flush any leftover request with a harmless active-to-active one
        wr(power_mode_pkg::MODE_REQ_ADDR, 32'h0);
        pulse();
        for (int i = 0; i < power_mode_pkg::WAKE_W; i++) begin
            wr(power_mode_pkg::WAKE_EN_ADDR, 32'h3F ^ (32'h1 << i));
            wr(power_mode_pkg::MODE_REQ_ADDR, 32'h2);
            pulse();
            rdChk(power_mode_pkg::MODE_STAT_ADDR, 32'h04);
            chk(32'({mainClkEn, slowClkEn, subsysClkEn}), 32'h100);
            if (i == 0) begin
                n = 0;
                repeat (32) begin
                    step(1);
                    n += int'(digRegEn === 1'b1) + int'(anaRegEn === 1'b1);
                end
                chk(32'(n), 32'h4);
            end
            wakeSrc[i] <= 1'b1;
            step(10);
            rdChk(power_mode_pkg::MODE_STAT_ADDR, 32'h04);
            wr(power_mode_pkg::WAKE_EN_ADDR, 32'h3F);
            waitWake();
            chk(32'(n >= 299 && n <= 310), 32'h1);
            rdChk(power_mode_pkg::IRQ_STAT_ADDR, 32'h2);
            wakeSrc[i] <= 1'b0;
            wr(power_mode_pkg::IRQ_CLR_ADDR, 32'h7);
            step(5);
        end
        wr(power_mode_pkg::MODE_REQ_ADDR, 32'h3);
        pulse();
        rdChk(power_mode_pkg::MODE_STAT_ADDR, 32'h08);
        chk(32'({mainClkEn, slowClkEn, digRegEn, anaRegEn, hibRegEn}), 32'h01);
        wakeSrc[power_mode_pkg::WK_RTC] <= 1'b1;
        step(10);
        rdChk(power_mode_pkg::MODE_STAT_ADDR, 32'h08);
        wakeSrc[power_mode_pkg::WK_PIN] <= 1'b1;
        waitWake();
        chk(32'(n <= 310), 32'h1);
        rdChk(power_mode_pkg::MODE_STAT_ADDR, 32'h01);
        wakeSrc <= 6'h00;
        wr(power_mode_pkg::REG_CTRL_ADDR, 32'h4);
        step(3);
        chk(32'({digRegEn, anaRegEn, xtalHighPower}), 32'h1);
        wr(power_mode_pkg::REG_CTRL_ADDR, 32'h3);
        step(3);
        chk(32'({digRegEn, anaRegEn, xtalHighPower}), 32'h6);
        wr(power_mode_pkg::IRQ_CLR_ADDR, 32'h7);
        wr(power_mode_pkg::IRQ_EN_ADDR, 32'h1);
        // One tick short of a second; toggling every cycle keeps the run short
        repeat (2 * 32767) begin
            @(posedge clk_sys);
            xtalTick <= ~xtalTick;
        end
        step(8);
        chk(32'(irq), 32'h0);
        xtalTick <= 1'b1;
        step(8);
        chk(32'(irq), 32'h1);
        printVerdict();
    end

endmodule : power_mode_controller_tb_top

`default_nettype wire
